// ### verilog/microcore_flow_control.v
// Purpose: Program flow and load-instruction sequencing of one microcore
// Assumes: Decoded operation, operands and conditions arrive synchronous to clk
// Notes: Data RAM is outside; this block issues address, data and strobes
`timescale 1ns/1ps
`default_nettype none
`include "flow_control_regs.vh"
module microcore_flow_control
(
    input wire clk,
    input wire reset_n,
    input wire instrValid,
    input wire [`OP_W-1:0] opCode,
    input wire [`REL_W-1:0] relOffset,
    input wire jumpSel,
    input wire [`COND_W-1:0] condCode,
    input wire [`WAIT_IDX_W-1:0] waitIdx,
    input wire waitEnable,
    input wire [`CORE_SEL_W-1:0] srcSel,
    input wire [`CORE_SEL_W-1:0] dstSel,
    input wire [`DATA_W-1:0] immData,
    input wire [`PC_W-1:0] ramAddr,
    input wire [`DATA_W-1:0] ramReadData,
    input wire [`COND_N-1:0] condBus,
    input wire irqRequest,
    input wire [`PC_W-1:0] irqVector,
    input wire iretToEntry,
    input wire [`PC_W-1:0] entryPoint,
    output reg [`PC_W-1:0] programCounter_r,
    output reg [`PC_W-1:0] returnPc_r,
    output reg waiting_r,
    output reg inIrq_r,
    output reg ramWriteEn_r,
    output reg [`PC_W-1:0] ramAddr_r,
    output reg [`DATA_W-1:0] ramWriteData_r,
    output reg [`DATA_W-1:0] outputCtrl_r,
    output reg [`DATA_W-1:0] multiplierResult_r
);

    ////////////////////////////////////////////////////////////////////////////////
    // Wait table storage
    reg [`WAIT_N-1:0] entryEnable_r;
    reg [`WAIT_N*`COND_W-1:0] entryCond_r;
    reg [`WAIT_N*`PC_W-1:0] entryDest_r;
    reg state_r;
    reg state_nxt;
    reg [`PC_W-1:0] pc_nxt;

    wire waitHit;
    wire [`WAIT_IDX_W-1:0] waitHitIdx;
    wire [`PC_W-1:0] jumpA;
    wire [`PC_W-1:0] jumpB;
    wire [`PC_W-1:0] farTarget;
    wire [`PC_W-1:0] relTarget;
    wire [`PC_W-1:0] seqPc;
    wire [`DATA_W-1:0] srcData;
    wire condTrue;
    wire isCondJump;
    wire irqTake;
    wire opTaken;
    wire isConfig;
    wire [`WAIT_N-1:0] entryWrite;

    reg rfWriteEn;
    reg [`CORE_SEL_W-1:0] rfWriteSel;
    reg [`DATA_W-1:0] rfWriteData;

    ////////////////////////////////////////////////////////////////////////////////
    // Address arithmetic
    assign farTarget = jumpSel ? jumpB : jumpA;
    // Offset is signed; sign extension lets short loops branch backwards
    assign relTarget = programCounter_r + {{(`PC_W-`REL_W){relOffset[`REL_W-1]}}, relOffset};
    assign seqPc = programCounter_r + `PC_ONE;
    assign condTrue = condBus[condCode];
    assign isCondJump = (opCode == `OP_JCR) || (opCode == `OP_JCF);
    // Only a newly taken interrupt drops the op; a request still high
    // inside the routine must not silence the routine's own loads
    assign irqTake = irqRequest && !inIrq_r;
    assign opTaken = instrValid && (state_r == `ST_RUN) && !irqTake;
    assign isConfig = (opCode == `OP_CWEF) || (opCode == `OP_CWER);

    core_register_file uRegs
    (
        .clk(clk),
        .reset_n(reset_n),
        .writeEn(rfWriteEn),
        .writeSel(rfWriteSel),
        .writeData(rfWriteData),
        .readSel(srcSel),
        .readData(srcData),
        .jumpA(jumpA),
        .jumpB(jumpB)
    );

    wait_entry_match uMatch
    (
        .entryEnable(entryEnable_r),
        .entryCond(entryCond_r),
        .condBus(condBus),
        .hit(waitHit),
        .hitIdx(waitHitIdx)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes for load-class instructions
    always @*
    begin
        rfWriteEn = 1'b0;
        rfWriteSel = `SEL_R0;
        rfWriteData = `DATA_RESET;
        if (opTaken)
        begin
            case (opCode)
                `OP_LOAD:
                begin
                    rfWriteEn = 1'b1;
                    rfWriteSel = dstSel;
                    rfWriteData = ramReadData;
                end
                `OP_COPY:
                begin
                    rfWriteEn = 1'b1;
                    rfWriteSel = dstSel;
                    rfWriteData = srcData;
                end
                `OP_LDCA, `OP_LDCD:
                begin
                    rfWriteEn = 1'b1;
                    rfWriteSel = `SEL_END_OF_COUNT_1 + {3'h0, waitIdx[1:0]};
                    rfWriteData = immData;
                end
                `OP_LDIR:
                begin
                    rfWriteEn = 1'b1;
                    rfWriteSel = `SEL_ML;
                    rfWriteData = immData;
                end
                `OP_LDIRH:
                begin
                    rfWriteEn = 1'b1;
                    rfWriteSel = `SEL_MH;
                    rfWriteData = immData;
                end
                `OP_LDJA:
                begin
                    rfWriteEn = 1'b1;
                    rfWriteSel = `SEL_JA;
                    rfWriteData = immData;
                end
                `OP_LDJB:
                begin
                    rfWriteEn = 1'b1;
                    rfWriteSel = `SEL_JB;
                    rfWriteData = immData;
                end
                default:
                begin
                    rfWriteEn = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next program counter and sequencer state
    always @*
    begin
        pc_nxt = programCounter_r;
        state_nxt = state_r;
        if (irqTake)
        begin
            pc_nxt = irqVector;
            state_nxt = `ST_RUN;
        end
        else if (state_r == `ST_WAIT)
        begin
            if (waitHit)
            begin
                pc_nxt = entryDest_r[waitHitIdx*`PC_W +: `PC_W];
                state_nxt = `ST_RUN;
            end
        end
        else if (instrValid)
        begin
            case (opCode)
                `OP_IRET:
                begin
                    pc_nxt = iretToEntry ? entryPoint : returnPc_r;
                end
                `OP_JCR:
                begin
                    pc_nxt = condTrue ? relTarget : seqPc;
                end
                `OP_JCF:
                begin
                    pc_nxt = condTrue ? farTarget : seqPc;
                end
                `OP_JMPR:
                begin
                    pc_nxt = relTarget;
                end
                `OP_JMPF:
                begin
                    pc_nxt = farTarget;
                end
                `OP_WAIT:
                begin
                    // Hold here; an immediate hit still costs one cycle of evaluation
                    pc_nxt = programCounter_r;
                    state_nxt = `ST_WAIT;
                end
                `OP_CWEF, `OP_CWER:
                begin
                    // Configuring an entry never starts the wait by itself
                    pc_nxt = seqPc;
                end
                `OP_LOAD, `OP_STORE, `OP_COPY, `OP_LDCA, `OP_LDCD,
                `OP_LDIR, `OP_LDIRH, `OP_LDJA, `OP_LDJB:
                begin
                    // Every load-class op retires in a single cycle
                    pc_nxt = seqPc;
                end
                default:
                begin
                    pc_nxt = seqPc;
                end
            endcase
        end
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            programCounter_r <= `PC_RESET;
            returnPc_r <= `PC_RESET;
            state_r <= `ST_RUN;
            waiting_r <= 1'b0;
            inIrq_r <= 1'b0;
        end
        else
        begin
            programCounter_r <= pc_nxt;
            state_r <= state_nxt;
            waiting_r <= state_nxt;
            if (irqTake)
            begin
                inIrq_r <= 1'b1;
                // Interrupted wait or conditional jump is re-executed on return
                if (state_r == `ST_WAIT || (instrValid && isCondJump))
                    returnPc_r <= programCounter_r;
                else
                    returnPc_r <= programCounter_r;
            end
            else if (instrValid && state_r == `ST_RUN && opCode == `OP_IRET)
            begin
                inIrq_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wait table configuration; never cleared by a completed wait
    genvar e;
    generate
        for (e = 0; e < `WAIT_N; e = e + 1)
        begin : gEntry
            // Only the addressed entry moves; the rest keep what an earlier wait used
            assign entryWrite[e] = opTaken && isConfig && (waitIdx == e);
            always @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    entryEnable_r[e] <= 1'b0;
                    entryCond_r[e*`COND_W +: `COND_W] <= {`COND_W{1'b0}};
                    entryDest_r[e*`PC_W +: `PC_W] <= `PC_RESET;
                end
                else if (entryWrite[e])
                begin
                    if (opCode == `OP_CWEF)
                    begin
                        entryEnable_r[e] <= waitEnable;
                        entryCond_r[e*`COND_W +: `COND_W] <= condCode;
                        entryDest_r[e*`PC_W +: `PC_W] <= farTarget;
                    end
                    else if (opCode == `OP_CWER)
                    begin
                        entryEnable_r[e] <= waitEnable;
                        entryCond_r[e*`COND_W +: `COND_W] <= condCode;
                        entryDest_r[e*`PC_W +: `PC_W] <= relTarget;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Data RAM, output control and multiplier result loads
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ramWriteEn_r <= 1'b0;
            ramAddr_r <= `PC_RESET;
            ramWriteData_r <= `DATA_RESET;
            outputCtrl_r <= `DATA_RESET;
            multiplierResult_r <= `DATA_RESET;
        end
        else
        begin
            ramWriteEn_r <= 1'b0;
            if (opTaken)
            begin
                ramAddr_r <= ramAddr;
                case (opCode)
                    `OP_STORE:
                    begin
                        ramWriteEn_r <= 1'b1;
                        ramWriteData_r <= srcData;
                    end
                    `OP_LDCA:
                    begin
                        outputCtrl_r <= immData;
                    end
                    // One port shows the last half loaded; the register file keeps both
                    `OP_LDIR:
                    begin
                        multiplierResult_r <= immData;
                    end
                    `OP_LDIRH:
                    begin
                        multiplierResult_r <= immData;
                    end
                    default:
                    begin
                        ramWriteEn_r <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // microcore_flow_control
`default_nettype wire

// ### verilog/flow_control_regs.vh
// Purpose: Constants for the microcore flow-control and load-instruction block
// Assumes: Decoded opcodes arrive one per cycle with an instruction-valid strobe
// Notes: Operation codes are a local encoding, not the bit-level instruction words
// How it works
// - Return from interrupt takes one cycle; resumes saved address or entry point.
// - Interrupted wait or conditional jump returns to itself to re-test feedbacks.
// - Relative conditional jump carries 6-bit offset; not taken goes to next word.
// - Taken relative conditional jump loads program counter with computed target.
// - Every relative conditional jump takes exactly one cycle, taken or not.
// - Far jump uses one of two 10-bit jump registers; load may precede directly.
// - Far jump never alters the jump register it reads.
// - Taken far conditional jump loads absolute address of selected jump register.
// - Every far conditional jump takes one cycle, taken or not.
// - Unconditional relative jump always adds offset and loads it in one cycle.
// - Unconditional far jump always loads selected jump register in one cycle.
// - Wait table has five entries: enable, 6-bit condition, 10-bit destination.
// - Wait destinations are stored as physical code addresses in any mode.
// - Each wait entry is set by its own far or relative configure instruction.
// - Wait table contents survive a completed wait for reuse or editing.
// - During wait the program counter holds until an enabled condition is true.
// - Fired entry jumps to far or relative-computed destination.
// - Conditions are not evaluated after the wait until another wait runs.
// - Load fills register from RAM, store writes it, copy moves register to register.
// - Two instructions load the four end-of-count registers; one also drives outputs.
// - Dedicated loads for jump registers and multiplier result; all nine are one cycle.
// - Arithmetic, core and jump operand subsets address their documented registers.
// - Core operand field is 5 bits, first register 00000, intercore register 11111.
// - Interrupt entry saves the program counter into the return register.
`ifndef FLOW_CONTROL_REGS_VH
`define FLOW_CONTROL_REGS_VH

`define PC_W 10
`define REL_W 6
`define COND_W 6
`define DATA_W 16
`define CORE_SEL_W 5
`define ARITH_SEL_W 3
`define WAIT_N 5
`define WAIT_IDX_W 3
`define COND_N 64
`define OP_W 5
`define PC_RESET 10'h000
`define PC_ONE 10'h001
`define DATA_RESET 16'h0000

`define OP_NOP 5'h00
`define OP_IRET 5'h01
`define OP_JCR 5'h02
`define OP_JCF 5'h03
`define OP_JMPR 5'h04
`define OP_JMPF 5'h05
`define OP_CWEF 5'h06
`define OP_CWER 5'h07
`define OP_WAIT 5'h08
`define OP_LOAD 5'h09
`define OP_STORE 5'h0a
`define OP_COPY 5'h0b
`define OP_LDCA 5'h0c
`define OP_LDCD 5'h0d
`define OP_LDIR 5'h0e
`define OP_LDIRH 5'h0f
`define OP_LDJA 5'h10
`define OP_LDJB 5'h11

`define SEL_R0 5'h00
`define SEL_IR 5'h05
`define SEL_MH 5'h06
`define SEL_ML 5'h07
`define SEL_JA 5'h0a
`define SEL_JB 5'h0b
`define SEL_END_OF_COUNT_1 5'h10
`define SEL_RXTX 5'h1f
`define GPR_N 6
`define EOC_N 4

`define ST_RUN 1'b0
`define ST_WAIT 1'b1

`endif

// ### verilog/wait_entry_match.v
// Purpose: Picks the lowest enabled wait entry whose condition is true
// Assumes: Condition bus is a flat vector indexed by the 6-bit condition code
// Notes: Purely combinational; the caller registers the outcome
`timescale 1ns/1ps
`default_nettype none
`include "flow_control_regs.vh"
module wait_entry_match
(
    input wire [`WAIT_N-1:0] entryEnable,
    input wire [`WAIT_N*`COND_W-1:0] entryCond,
    input wire [`COND_N-1:0] condBus,
    output reg hit,
    output reg [`WAIT_IDX_W-1:0] hitIdx
);
    wire [`WAIT_N-1:0] entryTrue;
    integer k;

    genvar g;
    generate
        for (g = 0; g < `WAIT_N; g = g + 1)
        begin : gTest
            assign entryTrue[g] = entryEnable[g] & condBus[entryCond[g*`COND_W +: `COND_W]];
        end
    endgenerate

    // Downward scan so the lowest index is assigned last
    always @*
    begin
        hit = 1'b0;
        hitIdx = {`WAIT_IDX_W{1'b0}};
        for (k = `WAIT_N-1; k >= 0; k = k - 1)
        begin
            if (entryTrue[k])
            begin
                hit = 1'b1;
                hitIdx = k[`WAIT_IDX_W-1:0];
            end
        end
    end
endmodule // wait_entry_match
`default_nettype wire

// ### verilog/core_register_file.v
// Purpose: Microcore register set reached by 5-bit operand selectors
// Assumes: One write port per cycle, one read port combinational
// Notes: All 32 register codes are held here; each reads back its last written value
`timescale 1ns/1ps
`default_nettype none
`include "flow_control_regs.vh"
module core_register_file
(
    input wire clk,
    input wire reset_n,
    input wire writeEn,
    input wire [`CORE_SEL_W-1:0] writeSel,
    input wire [`DATA_W-1:0] writeData,
    input wire [`CORE_SEL_W-1:0] readSel,
    output reg [`DATA_W-1:0] readData,
    output wire [`PC_W-1:0] jumpA,
    output wire [`PC_W-1:0] jumpB
);
    reg [`DATA_W-1:0] regs_r [0:31];
    integer i;

    // Full 32-entry array; unused codes simply never get written by software
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < 32; i = i + 1)
                regs_r[i] <= `DATA_RESET;
        end
        else if (writeEn)
        begin
            regs_r[writeSel] <= writeData;
        end
    end

    always @*
    begin
        readData = regs_r[readSel];
    end

    // Far jumps only read these, never write them
    assign jumpA = regs_r[`SEL_JA][`PC_W-1:0];
    assign jumpB = regs_r[`SEL_JB][`PC_W-1:0];
endmodule // core_register_file
`default_nettype wire

// ### test/flow_control_properties.sv
// Purpose: Port-level timing checks of the microcore flow control
// Assumes: Sees only top-level ports; decoded ops one per cycle
// Notes: Jump register contents are internal, so far targets are judged by the bench
`timescale 1ns/1ps
`default_nettype none
`include "flow_control_regs.vh"
module flow_control_properties
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instrValid,
    input wire logic [`OP_W-1:0] opCode,
    input wire logic [`REL_W-1:0] relOffset,
    input wire logic [`COND_W-1:0] condCode,
    input wire logic [`COND_N-1:0] condBus,
    input wire logic irqRequest,
    input wire logic [`PC_W-1:0] irqVector,
    input wire logic iretToEntry,
    input wire logic [`PC_W-1:0] entryPoint,
    input wire logic [`PC_W-1:0] ramAddr,
    input wire logic [`PC_W-1:0] programCounter_r,
    input wire logic [`PC_W-1:0] returnPc_r,
    input wire logic waiting_r,
    input wire logic inIrq_r,
    input wire logic ramWriteEn_r,
    input wire logic [`PC_W-1:0] ramAddr_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire accepted;
    wire [`PC_W-1:0] relTarget;
    // An accepted interrupt drops the op presented in the same cycle
    assign accepted = instrValid && !waiting_r && !(irqRequest && !inIrq_r);
    assign relTarget = programCounter_r + {{4{relOffset[5]}}, relOffset};
    sequence s_waitStay;
        waiting_r ##1 waiting_r;
    endsequence
    chk_jmpr_target: assert property (accepted && opCode == `OP_JMPR |=>
        programCounter_r == $past(relTarget)) else $error("relative jump target wrong");
    chk_jcr_branch: assert property (accepted && opCode == `OP_JCR |=> programCounter_r ==
        ($past(condBus[condCode]) ? $past(relTarget) : $past(programCounter_r) + `PC_ONE))
        else $error("relative conditional jump wrong");
    chk_jcf_skip: assert property (accepted && opCode == `OP_JCF && !condBus[condCode] |=>
        programCounter_r == $past(programCounter_r) + `PC_ONE) else $error("far jump not-taken wrong");
    chk_wait_entry: assert property (accepted && opCode == `OP_WAIT |=>
        waiting_r && $stable(programCounter_r)) else $error("wait entry wrong");
    chk_wait_hold: assert property (s_waitStay |-> $stable(programCounter_r))
        else $error("pc moved while waiting");
    chk_irq_entry: assert property (irqRequest && !inIrq_r |=> inIrq_r &&
        programCounter_r == $past(irqVector) && returnPc_r == $past(programCounter_r))
        else $error("interrupt entry wrong");
    chk_iret_resume: assert property (accepted && opCode == `OP_IRET && !iretToEntry |=>
        !inIrq_r && programCounter_r == $past(returnPc_r)) else $error("return to saved pc wrong");
    chk_iret_entry: assert property (accepted && opCode == `OP_IRET && iretToEntry |=>
        !inIrq_r && programCounter_r == $past(entryPoint)) else $error("return to entry wrong");
    chk_store_pulse: assert property (ramWriteEn_r |->
        $past(accepted && opCode == `OP_STORE) && ramAddr_r == $past(ramAddr)) else $error("stray write");
endmodule // flow_control_properties
bind microcore_flow_control flow_control_properties chk_inst (.clk(clk), .reset_n(reset_n),
    .instrValid(instrValid), .opCode(opCode), .relOffset(relOffset), .condCode(condCode), .condBus(condBus),
    .irqRequest(irqRequest), .irqVector(irqVector), .iretToEntry(iretToEntry), .entryPoint(entryPoint),
    .ramAddr(ramAddr), .programCounter_r(programCounter_r), .returnPc_r(returnPc_r), .waiting_r(waiting_r),
    .inIrq_r(inIrq_r), .ramWriteEn_r(ramWriteEn_r), .ramAddr_r(ramAddr_r));
`default_nettype wire

// ### test/microcore_flow_control_bench.sv
// Purpose: Directed bench for microcore flow control
// Assumes: Inputs change at falling edges, checks at falling edges
// Notes: Expected pc is tracked here, never read back from the block
`timescale 1ns/1ps
`default_nettype none
`include "flow_control_regs.vh"
module microcore_flow_control_bench;
    logic clk = 0, reset_n = 0, instrValid = 1, jumpSel = 0, waitEnable = 0, irqRequest = 0, iretToEntry = 0;
    logic [4:0] opCode = `OP_NOP, srcSel = 0, dstSel = 0;
    logic [5:0] relOffset = 0, condCode = 0;
    logic [2:0] waitIdx = 0;
    logic [15:0] immData = 0, ramReadData = 0, ramWriteData_r, outputCtrl_r, multiplierResult_r;
    logic [9:0] ramAddr = 0, irqVector = 10'h3a0, entryPoint = 10'h0f0, ePc, dest;
    logic [9:0] programCounter_r, returnPc_r, ramAddr_r;
    logic [63:0] condBus = 0;
    logic waiting_r, inIrq_r, ramWriteEn_r;
    int nFail = 0, nChecks = 0;
    microcore_flow_control microcore_flow_control_inst (.clk(clk), .reset_n(reset_n), .instrValid(instrValid),
        .opCode(opCode), .relOffset(relOffset), .jumpSel(jumpSel), .condCode(condCode), .waitIdx(waitIdx),
        .waitEnable(waitEnable), .srcSel(srcSel), .dstSel(dstSel), .immData(immData), .ramAddr(ramAddr),
        .ramReadData(ramReadData), .condBus(condBus), .irqRequest(irqRequest), .irqVector(irqVector),
        .iretToEntry(iretToEntry), .entryPoint(entryPoint), .programCounter_r(programCounter_r),
        .returnPc_r(returnPc_r), .waiting_r(waiting_r), .inIrq_r(inIrq_r), .ramWriteEn_r(ramWriteEn_r),
        .ramAddr_r(ramAddr_r), .ramWriteData_r(ramWriteData_r), .outputCtrl_r(outputCtrl_r),
        .multiplierResult_r(multiplierResult_r));
    initial
    begin
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task tallyAndFinish;
        if (nFail == 0 && nChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            nFail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered and left at a falling edge, so every input moves there
    task go(input logic [4:0] op);
        opCode = op;
        @(negedge clk);
        ePc = ePc + 10'h001;
    endtask
    task pcIs(input logic [9:0] exp);
        chk({6'h00, programCounter_r}, {6'h00, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_rel;
        relOffset = 6'h3d;
        go(`OP_JMPR);
        ePc = ePc - 10'h004;
        pcIs(ePc);
        condCode = 6'h07;
        go(`OP_JCR);
        pcIs(ePc);
        condBus[7] = 1'b1;
        relOffset = 6'h05;
        go(`OP_JCR);
        ePc = ePc + 10'h004;
        pcIs(ePc);
        condBus = 0;
    endtask
    task t_far;
        immData = 16'h0123;
        go(`OP_LDJA);
        immData = 16'h0234;
        go(`OP_LDJB);
        go(`OP_JMPF);
        ePc = 10'h123;
        pcIs(ePc);
        jumpSel = 1'b1;
        go(`OP_JCF);
        pcIs(ePc);
        condBus[9] = 1'b1;
        condCode = 6'h09;
        go(`OP_JCF);
        ePc = 10'h234;
        pcIs(ePc);
        jumpSel = 1'b0;
        go(`OP_JCF);
        ePc = 10'h123;
        pcIs(ePc);
        immData = 16'h0155;
        go(`OP_LDJA);
        go(`OP_JMPF);
        ePc = 10'h155;
        pcIs(ePc);
        condBus = 0;
    endtask
    // Stalls three cycles with conditions low, then fires
    task waitFire(input logic [9:0] target);
        go(`OP_WAIT);
        ePc = ePc - 10'h001;
        chk({15'h0000, waiting_r}, 16'h0001);
        repeat (3) go(`OP_NOP);
        ePc = ePc - 10'h003;
        pcIs(ePc);
        condBus[6:5] = 2'b11;
        go(`OP_NOP);
        ePc = target;
        pcIs(ePc);
        chk({15'h0000, waiting_r}, 16'h0000);
    endtask
    task t_wait;
        immData = 16'h0300;
        go(`OP_LDJA);
        waitIdx = 3'h0;
        condCode = 6'h05;
        waitEnable = 1'b1;
        go(`OP_CWEF);
        waitIdx = 3'h1;
        condCode = 6'h06;
        relOffset = 6'h04;
        dest = ePc + 10'h004;
        go(`OP_CWER);
        waitFire(10'h300);
        go(`OP_NOP);
        pcIs(ePc);
        condBus = 0;
        waitIdx = 3'h0;
        waitEnable = 1'b0;
        go(`OP_CWEF);
        waitFire(dest);
        condBus = 0;
    endtask
    task t_ram;
        ramReadData = 16'hbeef;
        dstSel = 5'h01;
        go(`OP_LOAD);
        srcSel = 5'h01;
        dstSel = 5'h1f;
        go(`OP_COPY);
        srcSel = 5'h1f;
        ramAddr = 10'h2a5;
        go(`OP_STORE);
        chk({15'h0000, ramWriteEn_r}, 16'h0001);
        chk({6'h00, ramAddr_r}, 16'h02a5);
        chk(ramWriteData_r, 16'hbeef);
        go(`OP_NOP);
        chk({15'h0000, ramWriteEn_r}, 16'h0000);
    endtask
    task t_load;
        immData = 16'h0a5c;
        waitIdx = 3'h2;
        go(`OP_LDCA);
        chk(outputCtrl_r, 16'h0a5c);
        immData = 16'h1234;
        waitIdx = 3'h3;
        go(`OP_LDCD);
        chk(outputCtrl_r, 16'h0a5c);
        srcSel = `SEL_END_OF_COUNT_1 + 5'h02;
        go(`OP_STORE);
        chk(ramWriteData_r, 16'h0a5c);
        srcSel = `SEL_END_OF_COUNT_1 + 5'h03;
        go(`OP_STORE);
        chk(ramWriteData_r, 16'h1234);
        immData = 16'h5678;
        go(`OP_LDIR);
        chk(multiplierResult_r, 16'h5678);
        immData = 16'h9abc;
        go(`OP_LDIRH);
        chk(multiplierResult_r, 16'h9abc);
        srcSel = `SEL_ML;
        go(`OP_STORE);
        chk(ramWriteData_r, 16'h5678);
        srcSel = `SEL_MH;
        go(`OP_STORE);
        chk(ramWriteData_r, 16'h9abc);
    endtask
    task t_irq;
        dest = ePc;
        condCode = 6'h02;
        irqRequest = 1'b1;
        go(`OP_JCR);
        pcIs(irqVector);
        chk({6'h00, returnPc_r}, {6'h00, dest});
        // Request still high inside the routine must not drop its own store
        go(`OP_STORE);
        chk({15'h0000, ramWriteEn_r}, 16'h0001);
        irqRequest = 1'b0;
        go(`OP_IRET);
        pcIs(dest);
        irqRequest = 1'b1;
        go(`OP_NOP);
        irqRequest = 1'b0;
        iretToEntry = 1'b1;
        go(`OP_IRET);
        pcIs(entryPoint);
        chk({15'h0000, inIrq_r}, 16'h0000);
        iretToEntry = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #40000;
        nFail++;
        tallyAndFinish;
    end
    initial
    begin
        ePc = 10'h000;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        ePc = 10'h000;
        pcIs(10'h000);
        go(`OP_NOP);
        t_rel;
        t_far;
        t_wait;
        t_ram;
        t_load;
        t_irq;
        tallyAndFinish;
    end
endmodule // microcore_flow_control_bench
`default_nettype wire
